//--- src/rt_status_word_flag_register.sv
// Host-maintained status word flag register of a remote terminal, with Wishbone access
//
// Contract
// - Every host-set flag is copied into each outgoing status word; here bit 15 (once-clear) is never copied into the word.
// - Dynamic bus control acceptance is never shown in the status word.
// - A set flag repeats in every response until cleared, unless once-clear is on.
// - Bits 4 and 10 ignore writes, read zero; device drives them in the word.
// - With once-clear set, the register clears after set bits 0-9 are sent once.
// - Transmit-status and last-command codes return the previous word unchanged.
// - Bits 14-10, 7-4 and 1 ignore writes and read zero.
// - Bit 9 asserts the instrumentation bit in the status word.
// - Bit 8 asserts the service request bit in the status word.
// - Bit 3 makes every valid command answer with busy.
// - A descriptor busy bit makes only that command answer with busy.
// - A busy response sends the status word alone, without data words.
// - A busy response sets the busy marker in the stored message word.
// - Sent subsystem flag is register bit 2 ORed with the input pin.
// - With vector-clear option 0, the vector code clears bit 2 before sending.
// - Bit 0 asserts the terminal flag bit in the status word.
// - Master or software reset clears every bit of the register.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ns
`include "rt_flag_params.svh"
module rt_status_word_flag_register
    import rt_flag_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic statusReq,
    input wire logic repeatStatusReq,
    input wire logic transmitVectorModeCode,
    input wire logic descBusy,
    input wire logic [4:0] rtAddress,
    input wire logic subsystemFlagPin,
    input wire logic broadcastReceivedBit,
    input wire logic messageErrorBit,
    output logic [15:0] statusWord,
    output logic statusValid,
    output logic dataSuppress,
    output logic messageBusyMarker
);
    // Whole state and its next value
    flag_state_t s_q;
    flag_state_t s_d;
    // Strobes and words passed between the submodules
    logic flagsWe;
    logic cfgWe;
    logic [15:0] wrData;
    logic [15:0] wrMask;
    logic [15:0] flagWrMask;
    logic [15:0] builtWord;
    logic [15:0] keptFlags;
    logic [15:0] cfgRdata;
    logic softReset;
    logic anySent;

    // Register bus slave
    wb_flag_slave wb_flag_slave_instrumentation_flag (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .flagsRdata(s_q.flags),
        .cfgRdata(cfgRdata),
        .lastRdata(s_q.lastWord),
        .flagsWe(flagsWe),
        .cfgWe(cfgWe),
        .wrData(wrData),
        .wrMask(wrMask)
    );

    // Status word assembly from the current register contents
    status_word_builder status_word_builder_instrumentation_flag (
        .flags(s_q.flags),
        .rtAddress(rtAddress),
        .descBusy(descBusy),
        .transmitVectorModeCode(transmitVectorModeCode),
        .vecClearOff(s_q.vecClearOff),
        .subsystemFlagPin(subsystemFlagPin),
        .broadcastReceivedBit(broadcastReceivedBit),
        .messageErrorBit(messageErrorBit),
        .word(builtWord),
        .keptFlags(keptFlags)
    );

    // Readback of configuration; soft reset bit always reads zero
    assign cfgRdata = {15'h0000, s_q.vecClearOff};

    // only documented flag bits are writable
    assign flagWrMask = wrMask & `FLAGS_WR_MASK;

    // Software reset is a write of one to its configuration bit
    assign softReset = cfgWe & wrMask[`CFG_SOFT_RST] & wrData[`CFG_SOFT_RST];

    // Any of bits 0-9 actually carried by the word being built
    assign anySent = |(keptFlags & `FLAGS_SEND_MASK);

    // Next state: word sampling first, then host writes, then soft reset
    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b0;
        if (statusReq) begin
            s_d.valid = 1'b1;
            if (repeatStatusReq) begin
                s_d.word = s_q.lastWord;
                s_d.suppress = s_q.lastWord[`BIT_BUSY];
                s_d.marker = s_q.lastWord[`BIT_BUSY];
            end else begin
                s_d.word = builtWord;
                s_d.lastWord = builtWord;
                // busy word goes out without data
                s_d.suppress = builtWord[`BIT_BUSY];
                // busy marker for message info word
                s_d.marker = builtWord[`BIT_BUSY];
                // vector code result kept in register
                s_d.flags = keptFlags;
                if (s_q.flags[`BIT_ONCE_CLEAR] && anySent) begin
                    s_d.flags = `FLAGS_RESET;
                end
            end
        end
        // host write persists; a set beats a hardware clear
        if (flagsWe) begin
            s_d.flags = (s_d.flags & ~flagWrMask) | (wrData & flagWrMask);
        end
        if (cfgWe && wrMask[`CFG_VEC_CLR_OFF]) begin
            s_d.vecClearOff = wrData[`CFG_VEC_CLR_OFF];
        end
        // software reset clears the flag register
        if (softReset) begin
            s_d.flags = `FLAGS_RESET;
        end
    end

    // State register; master reset loads all-zero constants
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign statusWord = s_q.word;
    assign statusValid = s_q.valid;
    assign dataSuppress = s_q.suppress;
    assign messageBusyMarker = s_q.marker;

    // Checks on the design's own behaviour
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // Shorthand for a fresh word request
    logic newReq;
    assign newReq = statusReq & ~repeatStatusReq;

    flag_copy_a: assert property (
        newReq |=> statusWord[9:8] == $past(s_q.flags[9:8])
    ) else $error("instrumentation or service flag not copied");

    no_dyn_bus_a: assert property (
        statusValid |-> !statusWord[`BIT_DYN_BUS]
    ) else $error("dynamic bus control bit set in status word");

    flag_hold_a: assert property (
        newReq && !s_q.flags[`BIT_ONCE_CLEAR] && !transmitVectorModeCode
        && !flagsWe && !softReset |=> $stable(s_q.flags)
    ) else $error("flag lost without host clear");

    dev_bits_a: assert property (
        newReq |=> statusWord[`BIT_MSG_ERR] == $past(messageErrorBit)
        && statusWord[`BIT_BCAST] == $past(broadcastReceivedBit)
    ) else $error("device-owned status bits wrong");

    once_clear_a: assert property (
        newReq && s_q.flags[`BIT_ONCE_CLEAR] && (|(s_q.flags & `FLAGS_SEND_MASK))
        && !transmitVectorModeCode && !flagsWe |=> s_q.flags == `FLAGS_RESET
    ) else $error("once-clear did not clear the register");

    repeat_word_a: assert property (
        statusReq && repeatStatusReq |=> statusWord == $past(s_q.lastWord)
        && $stable(s_q.lastWord)
    ) else $error("repeat mode code changed the word");

    unused_zero_a: assert property (
        (s_q.flags & ~`FLAGS_WR_MASK) == 16'h0000
    ) else $error("unused flag bit became set");

    term_flag_a: assert property (
        newReq |=> statusWord[`BIT_TERM] == $past(s_q.flags[`BIT_TERM])
    ) else $error("terminal flag not copied");

    busy_global_a: assert property (
        newReq && s_q.flags[`BIT_BUSY] |=> statusWord[`BIT_BUSY]
    ) else $error("global busy not reported");

    busy_desc_a: assert property (
        newReq |=> statusWord[`BIT_BUSY] == $past(s_q.flags[`BIT_BUSY] | descBusy)
    ) else $error("per-command busy wrong");

    busy_suppress_a: assert property (
        statusValid |-> dataSuppress == statusWord[`BIT_BUSY]
    ) else $error("data suppression does not follow busy");

    busy_marker_a: assert property (
        statusValid |-> messageBusyMarker == statusWord[`BIT_BUSY]
    ) else $error("busy marker does not follow busy");

    subsys_or_a: assert property (
        newReq && !transmitVectorModeCode |=>
        statusWord[`BIT_SUBSYS] == $past(s_q.flags[`BIT_SUBSYS] | subsystemFlagPin)
    ) else $error("subsystem flag is not the OR of bit and pin");

    vector_clear_a: assert property (
        newReq && transmitVectorModeCode && !s_q.vecClearOff && !flagsWe
        |=> !s_q.flags[`BIT_SUBSYS] && statusWord[`BIT_SUBSYS] == $past(subsystemFlagPin)
    ) else $error("vector code did not clear subsystem bit first");

    soft_reset_a: assert property (
        softReset |=> s_q.flags == `FLAGS_RESET
    ) else $error("software reset left flags set");

    sample_once_a: assert property (
        !statusReq |=> $stable(statusWord) && !statusValid
    ) else $error("status word changed outside a request");

    // Host write lands on the writable bits; it beats a same-edge hardware clear
    host_write_a: assert property (
        flagsWe && !softReset |=>
        (s_q.flags & $past(flagWrMask)) == ($past(wrData) & $past(flagWrMask))
    ) else $error("host write did not land on the flag register");

    // Nothing is cleared while no flag in bits 0-9 has been carried
    once_keep_a: assert property (
        newReq && s_q.flags[`BIT_ONCE_CLEAR] && !(|(s_q.flags & `FLAGS_SEND_MASK))
        && !flagsWe && !softReset |=> $stable(s_q.flags)
    ) else $error("once-clear fired with no flag sent");

    // The option stops the vector code from touching the register
    vector_keep_a: assert property (
        newReq && transmitVectorModeCode && s_q.vecClearOff && !s_q.flags[`BIT_ONCE_CLEAR]
        && !flagsWe && !softReset |=> $stable(s_q.flags)
    ) else $error("vector code cleared bit 2 with the option set");

    // Each fresh word is remembered for the repeat codes
    last_word_a: assert property (
        newReq |=> s_q.lastWord == statusWord
    ) else $error("last word register not updated");

    // A request always answers one cycle later
    valid_pulse_a: assert property (
        statusReq |=> statusValid
    ) else $error("status request not answered");

    // Repeated busy word still goes out without data
    busy_repeat_a: assert property (
        statusReq && repeatStatusReq |=> dataSuppress == $past(s_q.lastWord[`BIT_BUSY])
    ) else $error("repeated busy word not suppressing data");

    // Repeat codes leave the register alone
    repeat_keep_a: assert property (
        statusReq && repeatStatusReq && !flagsWe && !softReset |=> $stable(s_q.flags)
    ) else $error("repeat code changed the flag register");

    // Sent subsystem bit follows the pin even when the vector code clears bit 2
    pin_high_a: assert property (
        newReq && subsystemFlagPin |=> statusWord[`BIT_SUBSYS]
    ) else $error("subsystem pin not reflected");

    // Register reads show the sampled register; unused bits and bits 4, 10 stay zero
    flags_read_a: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i[8:2] == `FLAGS_IDX
        |-> wb_dat_o == {16'h0000, $past(s_q.flags)}
        && (wb_dat_o[15:0] & ~`FLAGS_WR_MASK) == 16'h0000
    ) else $error("flag register readback wrong");

    // Master reset clears the whole state, whatever was pending
    master_reset_a: assert property (
        disable iff (1'b0) sys_rst |=> s_q == '0
    ) else $error("master reset left state behind");

    // Main scenarios
    busy_resp_c: cover property (newReq && descBusy ##1 dataSuppress);
    once_clear_c: cover property (newReq && s_q.flags[`BIT_ONCE_CLEAR] ##1
        s_q.flags == `FLAGS_RESET ##[1:20] statusReq && repeatStatusReq);
    vector_clr_c: cover property (newReq && transmitVectorModeCode && s_q.flags[2]);
    host_write_c: cover property (flagsWe ##[1:20] newReq);
    soft_reset_c: cover property (softReset ##1 s_q.flags == `FLAGS_RESET);
endmodule

//--- src/rt_flag_params.svh
// Offsets, field positions and reset values of the status word flag register block
`ifndef RT_FLAG_PARAMS_SVH
`define RT_FLAG_PARAMS_SVH

// Register indices; byte address is four times the index
`define FLAGS_IDX 7'h07
`define CFG_IDX 7'h40
`define LAST_IDX 7'h41

// Flag register reset value and bit classes
`define FLAGS_RESET 16'h0000
`define FLAGS_WR_MASK 16'h830D
`define FLAGS_SEND_MASK 16'h03FF

// Bit positions in the flag register and in the status word
`define BIT_ONCE_CLEAR 15
`define BIT_MSG_ERR 10
`define BIT_INSTR 9
`define BIT_SVC_REQ 8
`define BIT_BCAST 4
`define BIT_BUSY 3
`define BIT_SUBSYS 2
`define BIT_DYN_BUS 1
`define BIT_TERM 0
`define RT_ADDR_LSB 11

// Configuration register fields and reset value
`define CFG_VEC_CLR_OFF 0
`define CFG_SOFT_RST 1
`define CFG_RESET 1'b0

`endif

//--- src/rt_flag_pkg.sv
// Types of the status word flag register block
package rt_flag_pkg;

    // Bus slave state: acknowledge and read data
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_state_t;

    // Flag block state: registers and the registered status word outputs
    typedef struct packed {
        logic [15:0] flags;
        logic vecClearOff;
        logic [15:0] lastWord;
        logic [15:0] word;
        logic valid;
        logic suppress;
        logic marker;
    } flag_state_t;

endpackage

//--- src/wb_flag_slave.sv
// Classic Wishbone slave for the flag, configuration and last word registers
`timescale 1ns/1ns
`include "rt_flag_params.svh"
module wb_flag_slave
    import rt_flag_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] flagsRdata,
    input wire logic [15:0] cfgRdata,
    input wire logic [15:0] lastRdata,
    output logic flagsWe,
    output logic cfgWe,
    output logic [15:0] wrData,
    output logic [15:0] wrMask
);
    wb_state_t s_q;
    wb_state_t s_d;
    logic req;
    logic [6:0] idx;

    // Request decode; the master holds everything until it sees ack
    assign req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[8:2];

    // Write strobes fire in the ack cycle, so the edge that ends it stores
    assign flagsWe = s_q.ack & req & wb_we_i & (idx == `FLAGS_IDX);
    assign cfgWe = s_q.ack & req & wb_we_i & (idx == `CFG_IDX);
    assign wrData = wb_dat_i[15:0];
    assign wrMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // One wait state, ack for one cycle; unmapped reads return zero
    always_comb begin
        s_d = s_q;
        s_d.ack = req & ~s_q.ack;
        s_d.dat = 32'h00000000;
        if (req && !s_q.ack && !wb_we_i) begin
            unique case (idx)
                `FLAGS_IDX: s_d.dat = {16'h0000, flagsRdata};
                `CFG_IDX: s_d.dat = {16'h0000, cfgRdata};
                `LAST_IDX: s_d.dat = {16'h0000, lastRdata};
                default: s_d.dat = 32'h00000000;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.dat;
endmodule

//--- src/status_word_builder.sv
// Combines the sampled flag register with device state into a new status word
`timescale 1ns/1ns
`include "rt_flag_params.svh"
module status_word_builder
    import rt_flag_pkg::*;
(
    input wire logic [15:0] flags,
    input wire logic [4:0] rtAddress,
    input wire logic descBusy,
    input wire logic transmitVectorModeCode,
    input wire logic vecClearOff,
    input wire logic subsystemFlagPin,
    input wire logic broadcastReceivedBit,
    input wire logic messageErrorBit,
    output logic [15:0] word,
    output logic [15:0] keptFlags
);
    // Word assembly; purely combinational, sampled by the caller
    always_comb begin
        keptFlags = flags;
        if (transmitVectorModeCode && !vecClearOff) begin
            keptFlags[`BIT_SUBSYS] = 1'b0;
        end
        word = 16'h0000;
        word[15:`RT_ADDR_LSB] = rtAddress;
        word[`BIT_MSG_ERR] = messageErrorBit;
        word[`BIT_BCAST] = broadcastReceivedBit;
        word[`BIT_INSTR] = keptFlags[`BIT_INSTR];
        word[`BIT_SVC_REQ] = keptFlags[`BIT_SVC_REQ];
        word[`BIT_BUSY] = keptFlags[`BIT_BUSY] | descBusy;
        word[`BIT_SUBSYS] = keptFlags[`BIT_SUBSYS] | subsystemFlagPin;
        word[`BIT_DYN_BUS] = 1'b0;
        word[`BIT_TERM] = keptFlags[`BIT_TERM];
    end
endmodule

//--- testbench/bus_controller_model.sv
// Bus controller model that issues commands and captures the status responses
`timescale 1ns/1ns
module bus_controller_model (
    input wire logic sys_clk,
    output logic statusReq,
    output logic repeatStatusReq,
    output logic transmitVectorModeCode,
    output logic descBusy,
    input wire logic [15:0] statusWord,
    input wire logic statusValid,
    input wire logic dataSuppress,
    input wire logic messageBusyMarker,
    output logic [31:0] rxWord,
    output logic rxSuppress,
    output logic rxMarker
);
    // Idle command lines at time zero
    initial begin
        statusReq = 1'b0;
        repeatStatusReq = 1'b0;
        transmitVectorModeCode = 1'b0;
        descBusy = 1'b0;
        rxWord = 32'h0000FFFF;
        rxSuppress = 1'b0;
        rxMarker = 1'b0;
    end

    // One command; qualifiers are scrambled once the request has been taken
    task issue(input logic rep, input logic vec, input logic busy);
        @(posedge sys_clk);
        statusReq <= 1'b1;
        repeatStatusReq <= rep;
        transmitVectorModeCode <= vec;
        descBusy <= busy;
        @(posedge sys_clk);
        statusReq <= 1'b0;
        repeatStatusReq <= ~rep;
        transmitVectorModeCode <= ~vec;
        descBusy <= ~busy;
        rxWord = 32'h0000FFFF;
        // capture each response; only the bench timeout ends a wait
        do begin
            @(posedge sys_clk);
        end while (statusValid !== 1'b1);
        rxWord = {16'h0000, statusWord};
        rxSuppress = dataSuppress;
        rxMarker = messageBusyMarker;
    endtask
endmodule

//--- testbench/rt_status_word_flag_register_test.sv
// Self-checking bench of the status word flag register block
`timescale 1ns/1ns
module rt_status_word_flag_register_test;
    logic sys_clk, sys_rst, wbCyc, wbStb, wbWe, wbAck, pin, bc, me;
    logic [8:0] wbAdr;
    logic [31:0] wbDatIn, wbDatOut, q;
    logic [3:0] wbSel;
    logic [4:0] rtAddr;
    logic sReq, sRep, sVec, sBusy, sValid, sSupp, sMark;
    logic [15:0] sWord;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;

    rt_status_word_flag_register rt_status_word_flag_register_instrumentation_flag (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_dat_i(wbDatIn), .wb_sel_i(wbSel), .wb_dat_o(wbDatOut),
        .wb_ack_o(wbAck), .statusReq(sReq), .repeatStatusReq(sRep),
        .transmitVectorModeCode(sVec), .descBusy(sBusy), .rtAddress(rtAddr),
        .subsystemFlagPin(pin), .broadcastReceivedBit(bc), .messageErrorBit(me),
        .statusWord(sWord), .statusValid(sValid), .dataSuppress(sSupp),
        .messageBusyMarker(sMark));
    bus_controller_model bus_controller_model_instrumentation_flag (.sys_clk(sys_clk), .statusReq(sReq),
        .repeatStatusReq(sRep), .transmitVectorModeCode(sVec), .descBusy(sBusy),
        .statusWord(sWord), .statusValid(sValid), .dataSuppress(sSupp),
        .messageBusyMarker(sMark), .rxWord(), .rxSuppress(), .rxMarker());

    // Clock of 100 ns
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Cut a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task end_sim();
        $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One classic Wishbone cycle; data is taken at the ack edge
    task wb(input logic we, input logic [6:0] idx, input logic [15:0] d,
            input logic [3:0] sel);
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbDatIn <= {16'h0000, d};
        wbSel <= sel;
        do begin
            @(posedge sys_clk);
        end while (wbAck !== 1'b1);
        q = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    function automatic logic [31:0] exp_word(input logic [15:0] f, input logic db);
        return {16'h0000, rtAddr, me, f[9], f[8], 3'b000, bc, f[3] | db, f[2] | pin,
                1'b0, f[0]};
    endfunction

    task cmd(input logic rep, input logic vec, input logic db);
        bus_controller_model_instrumentation_flag.issue(rep, vec, db);
    endtask

    // Reset values and unmapped access
    task test_reset();
        wb(0, 7'h07, 16'h0000, 4'hF);
        check(q, 32'h00000000);
        wb(1, 7'h22, 16'hFFFF, 4'hF);
        wb(0, 7'h22, 16'h0000, 4'hF);
        check(q, 32'h00000000);
        $display("test reset done");
    endtask

    // Writable bits, byte lanes, and copying into every response
    task test_flags();
        wb(1, 7'h07, 16'hFFFF, 4'h1);
        check(q, 32'h00000000);
        wb(0, 7'h07, 16'h0000, 4'hF);
        check(q, 32'h0000000D);
        wb(1, 7'h07, 16'hFFFF, 4'hF);
        wb(0, 7'h07, 16'h0000, 4'hF);
        check(q, 32'h0000830D);
        wb(1, 7'h07, 16'h7FFF, 4'hF);
        repeat (2) begin
            cmd(0, 0, 0);
            check(bus_controller_model_instrumentation_flag.rxWord, exp_word(16'h030D, 0));
            check(bus_controller_model_instrumentation_flag.rxSuppress, 1'b1);
            check(bus_controller_model_instrumentation_flag.rxMarker, 1'b1);
        end
        wb(0, 7'h41, 16'h0000, 4'hF);
        check(q, exp_word(16'h030D, 0));
        $display("test flags done");
    endtask

    // Single flags one at a time, with device bits and descriptor busy
    task test_single();
        logic [15:0] f [4];
        f = '{16'h0200, 16'h0100, 16'h0001, 16'h0000};
        for (int i = 0; i < 4; i++) begin
            bc <= i[0];
            me <= ~i[0];
            wb(1, 7'h07, f[i], 4'hF);
            cmd(0, 0, i == 3);
            // Instrumentation, service request, terminal flag, descriptor busy in turn
            check(bus_controller_model_instrumentation_flag.rxWord, exp_word(f[i], i == 3));
            check(bus_controller_model_instrumentation_flag.rxMarker, i == 3);
        end
        pin <= 1'b1;
        cmd(0, 0, 0);
        check(bus_controller_model_instrumentation_flag.rxWord, exp_word(16'h0000, 0));
        pin <= 1'b0;
        $display("test single done");
    endtask

    // Vector code clearing the subsystem flag, and the option that stops it
    task test_vector();
        wb(1, 7'h07, 16'h0004, 4'hF);
        cmd(0, 1, 0);
        check(bus_controller_model_instrumentation_flag.rxWord, exp_word(16'h0000, 0));
        wb(0, 7'h07, 16'h0000, 4'hF);
        check(q, 32'h00000000);
        wb(1, 7'h40, 16'h0001, 4'hF);
        wb(1, 7'h07, 16'h0004, 4'hF);
        cmd(0, 1, 0);
        check(bus_controller_model_instrumentation_flag.rxWord, exp_word(16'h0004, 0));
        wb(0, 7'h07, 16'h0000, 4'hF);
        check(q, 32'h00000004);
        $display("test vector done");
    endtask

    // Transmit once and clear, then the repeat codes, then software reset
    task test_once();
        wb(1, 7'h07, 16'h8200, 4'hF);
        cmd(0, 0, 0);
        check(bus_controller_model_instrumentation_flag.rxWord, exp_word(16'h0200, 0));
        wb(0, 7'h07, 16'h0000, 4'hF);
        check(q, 32'h00000000);
        cmd(1, 0, 0);
        check(bus_controller_model_instrumentation_flag.rxWord, exp_word(16'h0200, 0));
        cmd(0, 0, 0);
        check(bus_controller_model_instrumentation_flag.rxWord, exp_word(16'h0000, 0));
        wb(1, 7'h07, 16'h0309, 4'hF);
        wb(1, 7'h40, 16'h0002, 4'hF);
        wb(0, 7'h07, 16'h0000, 4'hF);
        check(q, 32'h00000000);
        $display("test once done");
    endtask

    // Master reset in mid-run clears flags and configuration
    task test_master();
        wb(1, 7'h07, 16'h030D, 4'hF);
        wb(1, 7'h40, 16'h0001, 4'hF);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wb(0, 7'h07, 16'h0000, 4'hF);
        check(q, 32'h00000000);
        wb(0, 7'h40, 16'h0000, 4'hF);
        check(q, 32'h00000000);
        $display("test master done");
    endtask

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        {wbCyc, wbStb, wbWe, pin, bc, me} = 6'h00;
        wbAdr = 9'h000;
        wbDatIn = 32'h00000000;
        wbSel = 4'h0;
        rtAddr = 5'h15;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        test_reset();
        test_flags();
        test_single();
        test_vector();
        test_once();
        test_master();
        end_sim();
    end
endmodule
